// ===== hw/ops_pkg.sv
package ops_pkg;
    // Register offsets on the control port
    localparam logic [7:0] OPS_ADDR_POWER = 8'h00;
    localparam logic [7:0] OPS_ADDR_PHONES = 8'h08;
    localparam logic [7:0] OPS_ADDR_LINE = 8'h09;

    // Values after reset: everything off, muted, ramps enabled
    localparam logic [7:0] OPS_POWER_RESET = 8'h00;
    localparam logic [7:0] OPS_PHONES_RESET = 8'h00;
    localparam logic [7:0] OPS_LINE_RESET = 8'h00;

    // Bit positions in power_management_a
    localparam int OPS_PWR_LINE = 0;
    localparam int OPS_PWR_HP_LEFT = 1;
    localparam int OPS_PWR_HP_RIGHT = 2;
    localparam int OPS_PWR_PUMP = 3;
    localparam int OPS_PWR_BYPASS = 4;
    localparam int OPS_PWR_RAMP_LO = 5;
    localparam int OPS_PWR_GAIN = 7;

    // Bit positions in headphone_path_select and line_path_select
    localparam int OPS_PATH_DAC_L = 0;
    localparam int OPS_PATH_IN_L = 1;
    localparam int OPS_PATH_MONO_L = 2;
    localparam int OPS_PATH_DAC_R = 3;
    localparam int OPS_PATH_IN_R = 4;
    localparam int OPS_PATH_MONO_R = 5;
    localparam int OPS_HP_UNMUTE = 6;
    localparam int OPS_HP_BYPASS = 7;
    localparam int OPS_LN_BYPASS = 6;
    localparam int OPS_LN_MONO_MIX = 7;

    // Timer width: the longest count is 6146 sample periods
    localparam int OPS_CNT_W = 13;

    // Transition counts at each rate code, shortest setting
    localparam logic [12:0] OPS_TR_48K = 13'h0300;
    localparam logic [12:0] OPS_TR_32K = 13'h0200;
    localparam logic [12:0] OPS_TR_24K = 13'h0180;
    localparam logic [12:0] OPS_TR_16K = 13'h0100;
    localparam logic [12:0] OPS_TR_12K = 13'h00C0;
    localparam logic [12:0] OPS_TR_8K = 13'h0080;
    // Power ramp runs two periods longer than a transition
    localparam logic [12:0] OPS_RAMP_EXTRA = 13'h0002;

    // Charge pump power-up counts per rate tier
    localparam logic [12:0] OPS_CP_FULL = 13'h0200;
    localparam logic [12:0] OPS_CP_HALF = 13'h0100;
    localparam logic [12:0] OPS_CP_QUARTER = 13'h0080;
    localparam logic [12:0] OPS_CP_EIGHTH = 13'h0040;

    // Source selection driven toward each summing node
    typedef enum logic [1:0] {
        OPS_SRC_OFF = 2'h0,
        OPS_SRC_OWN = 2'h1,
        OPS_SRC_AVG = 2'h2
    } ops_src_t;

    // Base transition count for a sample-rate code
    function automatic logic [12:0] ops_tr_base(input logic [3:0] code);
        logic [12:0] r;
        r = OPS_TR_48K;
        case (code)
            4'h1: r = OPS_TR_32K;
            4'h8, 4'hA: r = OPS_TR_24K;
            4'h9: r = OPS_TR_16K;
            4'hC, 4'hE: r = OPS_TR_12K;
            4'hD: r = OPS_TR_8K;
            default: r = OPS_TR_48K;
        endcase
        return r;
    endfunction : ops_tr_base

    // Charge pump count for a sample-rate code
    function automatic logic [12:0] ops_cp_count(input logic [3:0] code);
        logic [12:0] r;
        r = OPS_CP_FULL;
        case (code)
            4'h1, 4'h8, 4'hA: r = OPS_CP_HALF;
            4'h9, 4'hC, 4'hE: r = OPS_CP_QUARTER;
            4'hD: r = OPS_CP_EIGHTH;
            default: r = OPS_CP_FULL;
        endcase
        return r;
    endfunction : ops_cp_count
endpackage : ops_pkg

// ===== hw/ops_timer.sv
`timescale 1ns/1ps
module ops_timer
    import ops_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic load_i,
    input wire logic [OPS_CNT_W-1:0] count_i,
    input wire logic tick_i,
    output logic busy_o
);
    // Whole timer state
    typedef struct packed {
        logic [OPS_CNT_W-1:0] cnt;
        logic busy;
    } ops_timer_st_t;

    ops_timer_st_t q;
    ops_timer_st_t next_q;

    // Load wins over a tick so a new write restarts the full period
    always_comb begin
        next_q = q;
        if (load_i) begin
            next_q.cnt = count_i;
            next_q.busy = (count_i != '0);
        end else if (tick_i && q.busy) begin
            next_q.cnt = q.cnt - 1'b1;
            next_q.busy = (q.cnt != 13'h0001);
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign busy_o = q.busy;

    // The period ends on a frame tick, or at once on a bypassed load of zero
    timer_end_tick_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(busy_o) |-> ($past(tick_i) && !$past(load_i))
        || ($past(load_i) && $past(count_i) == '0))
        else $error("timer ended without a frame tick");
endmodule : ops_timer

// ===== hw/ops_output_path.sv
`timescale 1ns/1ps
// Summary of operation
// - Line stage powered only while its bit set
// - Six line source paths switch independently
// - Line DAC path carries own or averaged DAC
// - Six phones source paths switch independently
// - Phones DAC path carries own or averaged DAC
// - Gain bit picks low or high phones swing
// - Phones off, muted or passing per bits
// - Mute change ramps unless its bypass set
// - Both power bits clear grounds phones pins
// - Phones power ramps unless ramp bypass set
// - Transition time covers mute, paths, gain rise
// - Write equal to previous value is ignored
// - Power ramp on power bits, transitions on paths
// - Power ramp counts 130 up to 6146 periods
// - Transition counts 128 up to 6144 periods
// - Charge pump ready after rate-scaled periods
// - Nine valid rate codes, others unused
// - Level-control gain rises soft unless bypassed
module ops_output_path
    import ops_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    input wire logic frame_clock_i,
    input wire logic [3:0] sample_rate_code_i,
    input wire logic [1:0] transition_time_sel_i,
    input wire logic phones_mono_mix_i,
    input wire logic playback_level_control_enable_i,
    input wire logic level_gain_step_i,
    output logic line_stage_power_o,
    output logic [1:0] line_left_dac_src_o,
    output logic [1:0] line_right_dac_src_o,
    output logic [3:0] line_input_paths_o,
    output logic line_switch_ramp_o,
    output logic [1:0] phones_left_dac_src_o,
    output logic [1:0] phones_right_dac_src_o,
    output logic [3:0] phones_input_paths_o,
    output logic phones_switch_ramp_o,
    output logic phones_gain_high_o,
    output logic phones_left_powered_o,
    output logic phones_right_powered_o,
    output logic phones_power_ramp_o,
    output logic phones_grounded_o,
    output logic phones_muted_o,
    output logic charge_pump_on_o,
    output logic charge_pump_ready_o,
    output logic level_gain_ramp_o,
    output logic level_gain_apply_o
);
    // Whole block state
    typedef struct packed {
        logic [2:0] fsync;      // Frame clock synchroniser chain
        logic fstable;          // Agreed frame clock level
        logic tick;             // One cycle per sample period
        logic [7:0] pwr;        // power_management_a
        logic [7:0] hp;         // headphone_path_select
        logic [7:0] ln;         // line_path_select
        logic [7:0] rd_data;    // Read-back word
        logic [1:0] ll_src;
        logic [1:0] lr_src;
        logic [1:0] hl_src;
        logic [1:0] hr_src;
        logic grounded;
        logic pump_ready;
        logic gain_apply;
    } ops_state_t;

    ops_state_t q;
    ops_state_t next_q;

    // Write acceptance and timer control
    logic acc_pwr;              // Accepted, changed power register write
    logic acc_hp;
    logic acc_ln;
    logic pwr_load;
    logic hp_load;
    logic ln_load;
    logic cp_load;
    logic gain_load;
    logic [OPS_CNT_W-1:0] tr_count;
    logic [OPS_CNT_W-1:0] ramp_count;
    logic [OPS_CNT_W-1:0] cp_count;
    // Busy flags of the five timers
    logic pwr_busy;
    logic hp_busy;
    logic ln_busy;
    logic cp_busy;
    logic gain_busy;

    // Source choice for one DAC summing path
    function automatic logic [1:0] pick_src(input logic en, input logic mix);
        logic [1:0] r;
        r = OPS_SRC_OFF;
        if (en) begin
            r = mix ? OPS_SRC_AVG : OPS_SRC_OWN;
        end
        return r;
    endfunction : pick_src

    // Write filter: a repeat of the stored value starts nothing
    always_comb begin
        acc_pwr = wr_en_i && (wr_addr_i == OPS_ADDR_POWER) && (wr_data_i != q.pwr);
        acc_hp = wr_en_i && (wr_addr_i == OPS_ADDR_PHONES) && (wr_data_i != q.hp);
        acc_ln = wr_en_i && (wr_addr_i == OPS_ADDR_LINE) && (wr_data_i != q.ln);
    end

    // Rate-scaled counts; invalid rate codes fall back to the default row
    always_comb begin
        tr_count = ops_tr_base(sample_rate_code_i) << transition_time_sel_i;
        // Power ramp follows its own select bits, taken from the write itself
        ramp_count = (ops_tr_base(sample_rate_code_i) << wr_data_i[OPS_PWR_RAMP_LO +: 2])
            + OPS_RAMP_EXTRA;
        cp_count = ops_cp_count(sample_rate_code_i);
    end

    // Timer starts; a bypassed write loads zero into the power, phones or line timer, ending its ramp at once; the pump timer always loads its count
    always_comb begin
        pwr_load = acc_pwr
            && (wr_data_i[OPS_PWR_HP_RIGHT:OPS_PWR_HP_LEFT]
                != q.pwr[OPS_PWR_HP_RIGHT:OPS_PWR_HP_LEFT]);
        hp_load = acc_hp;
        ln_load = acc_ln;
        cp_load = acc_pwr && wr_data_i[OPS_PWR_PUMP] && !q.pwr[OPS_PWR_PUMP];
        gain_load = level_gain_step_i && playback_level_control_enable_i;
    end

    // Phones power ramp timer
    ops_timer u_pwr_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(pwr_load),
        .count_i(wr_data_i[OPS_PWR_BYPASS] ? '0 : ramp_count),
        .tick_i(q.tick),
        .busy_o(pwr_busy)
    );

    // Phones mute and path transition timer
    ops_timer u_hp_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(hp_load),
        .count_i(wr_data_i[OPS_HP_BYPASS] ? '0 : tr_count),
        .tick_i(q.tick),
        .busy_o(hp_busy)
    );

    // Line path transition timer
    ops_timer u_ln_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(ln_load),
        .count_i(wr_data_i[OPS_LN_BYPASS] ? '0 : tr_count),
        .tick_i(q.tick),
        .busy_o(ln_busy)
    );

    // Charge pump start-up timer
    ops_timer u_cp_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(cp_load),
        .count_i(cp_count),
        .tick_i(q.tick),
        .busy_o(cp_busy)
    );

    // Level-control gain rise timer, shares the line bypass
    ops_timer u_gain_timer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(gain_load),
        .count_i(q.ln[OPS_LN_BYPASS] ? '0 : tr_count),
        .tick_i(q.tick),
        .busy_o(gain_busy)
    );

    // Next-state logic
    always_comb begin
        next_q = q;
        // Frame clock: only the second and third stages are compared
        next_q.fsync = {q.fsync[1:0], frame_clock_i};
        next_q.tick = 1'b0;
        if (q.fsync[1] == q.fsync[2] && q.fsync[2] != q.fstable) begin
            next_q.fstable = q.fsync[2];
            next_q.tick = q.fsync[2];
        end
        // Register writes that survive the repeat filter
        if (acc_pwr) begin
            next_q.pwr = wr_data_i;
        end
        if (acc_hp) begin
            next_q.hp = wr_data_i;
        end
        if (acc_ln) begin
            next_q.ln = wr_data_i;
        end
        // Read-back, unmapped addresses read zero
        if (rd_addr_i == OPS_ADDR_POWER) begin
            next_q.rd_data = q.pwr;
        end else if (rd_addr_i == OPS_ADDR_PHONES) begin
            next_q.rd_data = q.hp;
        end else if (rd_addr_i == OPS_ADDR_LINE) begin
            next_q.rd_data = q.ln;
        end else begin
            next_q.rd_data = 8'h00;
        end
        // DAC feeds into each summing node
        next_q.ll_src = pick_src(next_q.ln[OPS_PATH_DAC_L], next_q.ln[OPS_LN_MONO_MIX]);
        next_q.lr_src = pick_src(next_q.ln[OPS_PATH_DAC_R], next_q.ln[OPS_LN_MONO_MIX]);
        next_q.hl_src = pick_src(next_q.hp[OPS_PATH_DAC_L], phones_mono_mix_i);
        next_q.hr_src = pick_src(next_q.hp[OPS_PATH_DAC_R], phones_mono_mix_i);
        // Pins go to ground only once the power-down ramp is over
        next_q.grounded = !next_q.pwr[OPS_PWR_HP_LEFT] && !next_q.pwr[OPS_PWR_HP_RIGHT]
            && !pwr_busy && !pwr_load;
        // Pump ready once its count has run out
        next_q.pump_ready = next_q.pwr[OPS_PWR_PUMP] && !cp_busy && !cp_load;
        // Gain step goes straight through, bypassed or not
        next_q.gain_apply = gain_load;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.pwr <= OPS_POWER_RESET;
            q.hp <= OPS_PHONES_RESET;
            q.ln <= OPS_LINE_RESET;
        end else begin
            q <= next_q;
        end
    end

    // Outputs, all from flip-flops
    assign rd_data_o = q.rd_data;
    assign line_stage_power_o = q.pwr[OPS_PWR_LINE];
    assign line_left_dac_src_o = q.ll_src;
    assign line_right_dac_src_o = q.lr_src;
    assign line_input_paths_o = {q.ln[OPS_PATH_MONO_R], q.ln[OPS_PATH_IN_R],
        q.ln[OPS_PATH_MONO_L], q.ln[OPS_PATH_IN_L]};
    assign line_switch_ramp_o = ln_busy;
    assign phones_left_dac_src_o = q.hl_src;
    assign phones_right_dac_src_o = q.hr_src;
    assign phones_input_paths_o = {q.hp[OPS_PATH_MONO_R], q.hp[OPS_PATH_IN_R],
        q.hp[OPS_PATH_MONO_L], q.hp[OPS_PATH_IN_L]};
    assign phones_switch_ramp_o = hp_busy;
    assign phones_gain_high_o = q.pwr[OPS_PWR_GAIN];
    assign phones_left_powered_o = q.pwr[OPS_PWR_HP_LEFT];
    assign phones_right_powered_o = q.pwr[OPS_PWR_HP_RIGHT];
    assign phones_power_ramp_o = pwr_busy;
    assign phones_grounded_o = q.grounded;
    assign phones_muted_o = !q.hp[OPS_HP_UNMUTE];
    assign charge_pump_on_o = q.pwr[OPS_PWR_PUMP];
    assign charge_pump_ready_o = q.pump_ready;
    assign level_gain_ramp_o = gain_busy;
    assign level_gain_apply_o = q.gain_apply;

    // Assertions run on the system clock and rest during reset
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // A soft phones write and the ramp it must start
    sequence hp_soft_write;
        acc_hp && !wr_data_i[OPS_HP_BYPASS];
    endsequence

    sequence hp_ramp_holds;
        phones_switch_ramp_o [*3];
    endsequence

    line_power_write_a: assert property (
        wr_en_i && wr_addr_i == OPS_ADDR_POWER |=> line_stage_power_o == $past(wr_data_i[0]))
        else $error("line stage power not taken from write");
    repeat_write_a: assert property (
        wr_en_i && wr_addr_i == OPS_ADDR_PHONES && wr_data_i == q.hp
        && !phones_switch_ramp_o |=> !phones_switch_ramp_o)
        else $error("repeat write started a transition");
    line_mix_src_a: assert property (
        line_right_dac_src_o == OPS_SRC_AVG |-> q.ln[OPS_LN_MONO_MIX] && q.ln[OPS_PATH_DAC_R])
        else $error("line average without mix and path");
    phones_off_src_a: assert property (
        !q.hp[OPS_PATH_DAC_L] |-> phones_left_dac_src_o == OPS_SRC_OFF)
        else $error("phones dac path fed while disabled");
    gain_select_a: assert property (
        wr_en_i && wr_addr_i == OPS_ADDR_POWER ##1 1'b1 |-> phones_gain_high_o == $past(wr_data_i[7]))
        else $error("phones gain not taken from write");
    mute_bypass_a: assert property (
        acc_hp && wr_data_i[OPS_HP_BYPASS] |=> !phones_switch_ramp_o)
        else $error("bypassed mute change still ramping");
    mute_soft_a: assert property (
        hp_soft_write |=> hp_ramp_holds)
        else $error("soft mute change ended too early");
    // Pin state and ramp timer checks
    grounded_pins_a: assert property (
        phones_grounded_o |-> !phones_left_powered_o && !phones_right_powered_o
        && !phones_power_ramp_o)
        else $error("phones grounded while powered or ramping");
    pump_ready_a: assert property (
        $rose(charge_pump_ready_o) |-> charge_pump_on_o && $past(q.tick, 2))
        else $error("charge pump ready without its count");
    power_bypass_a: assert property (
        pwr_load && wr_data_i[OPS_PWR_BYPASS] |=> !phones_power_ramp_o)
        else $error("bypassed power change still ramping");
    // Checks on paths, mute, bypass, phones mix, level-control steps and pump start-up
    line_paths_a: assert property (
        acc_ln |=> line_input_paths_o
        == {$past(wr_data_i[OPS_PATH_IN_R +: 2]), $past(wr_data_i[OPS_PATH_IN_L +: 2])})
        else $error("line paths not taken from write");
    phones_paths_a: assert property (
        acc_hp |=> phones_input_paths_o
        == {$past(wr_data_i[OPS_PATH_IN_R +: 2]), $past(wr_data_i[OPS_PATH_IN_L +: 2])})
        else $error("phones paths not taken from write");
    mute_state_a: assert property (
        acc_hp |=> phones_muted_o == !$past(wr_data_i[OPS_HP_UNMUTE]))
        else $error("mute state not taken from write");
    line_bypass_a: assert property (
        acc_ln && wr_data_i[OPS_LN_BYPASS] |=> !line_switch_ramp_o)
        else $error("bypassed line change still ramping");
    phones_mix_a: assert property (
        phones_left_dac_src_o == OPS_SRC_AVG |-> $past(phones_mono_mix_i))
        else $error("phones average without mix");
    gain_step_a: assert property (
        gain_load |=> level_gain_apply_o)
        else $error("gain step not applied");
    gain_off_a: assert property (
        level_gain_step_i && !playback_level_control_enable_i |=> !level_gain_apply_o)
        else $error("gain step applied while disabled");
    pump_wait_a: assert property (
        cp_load |=> !charge_pump_ready_o && charge_pump_on_o)
        else $error("charge pump ready before its count");
endmodule : ops_output_path

// ===== testbench/ops_load_model.sv
`timescale 1ns/1ps
// Host clocking seen by the output stage: a free-running frame clock
module ops_load_model (
    input wire logic run_i,
    output logic frame_clock_o
);
    // Eight system clocks per frame, phase unrelated to the system clock
    initial begin
        frame_clock_o = 1'b0;
        #13;
        forever begin
            #160;
            frame_clock_o = run_i ? ~frame_clock_o : 1'b0;
        end
    end
endmodule : ops_load_model

// ===== testbench/ops_output_path_bench.sv
`timescale 1ns/1ps
module ops_output_path_bench;
    import ops_pkg::*;
    logic clk_i, resetn_i, wr_en_i, frame_clock_i, phones_mono_mix_i, level_gain_step_i;
    logic playback_level_control_enable_i, line_stage_power_o, line_switch_ramp_o;
    logic phones_switch_ramp_o, phones_gain_high_o, phones_left_powered_o;
    logic phones_right_powered_o, phones_power_ramp_o, phones_grounded_o, phones_muted_o;
    logic charge_pump_on_o, charge_pump_ready_o, level_gain_ramp_o, level_gain_apply_o;
    logic [7:0] wr_addr_i, wr_data_i, rd_addr_i, rd_data_o;
    logic [3:0] sample_rate_code_i, line_input_paths_o, phones_input_paths_o;
    logic [1:0] transition_time_sel_i, line_left_dac_src_o, line_right_dac_src_o;
    logic [1:0] phones_left_dac_src_o, phones_right_dac_src_o;
    logic [7:0] mdl [3]; // Register model: power, phones, line
    int mismatches, num_checks, seed;
    // Rate codes with their transition and pump counts at the shortest setting
    int codes [9] = '{0, 1, 2, 8, 9, 10, 12, 13, 14};
    int tr [9] = '{768, 512, 768, 384, 256, 384, 192, 128, 192};
    int cp [9] = '{512, 256, 512, 256, 128, 256, 128, 64, 128};

    ops_load_model load (.run_i(resetn_i | 1'b1), .frame_clock_o(frame_clock_i));
    ops_output_path dut (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .frame_clock_i(frame_clock_i),
        .sample_rate_code_i(sample_rate_code_i), .transition_time_sel_i(transition_time_sel_i),
        .phones_mono_mix_i(phones_mono_mix_i), .level_gain_step_i(level_gain_step_i),
        .playback_level_control_enable_i(playback_level_control_enable_i),
        .line_stage_power_o(line_stage_power_o), .line_left_dac_src_o(line_left_dac_src_o),
        .line_right_dac_src_o(line_right_dac_src_o), .line_input_paths_o(line_input_paths_o),
        .line_switch_ramp_o(line_switch_ramp_o), .phones_left_dac_src_o(phones_left_dac_src_o),
        .phones_right_dac_src_o(phones_right_dac_src_o),
        .phones_input_paths_o(phones_input_paths_o), .phones_switch_ramp_o(phones_switch_ramp_o),
        .phones_gain_high_o(phones_gain_high_o), .phones_left_powered_o(phones_left_powered_o),
        .phones_right_powered_o(phones_right_powered_o),
        .phones_power_ramp_o(phones_power_ramp_o), .phones_grounded_o(phones_grounded_o),
        .phones_muted_o(phones_muted_o), .charge_pump_on_o(charge_pump_on_o),
        .charge_pump_ready_o(charge_pump_ready_o), .level_gain_ramp_o(level_gain_ramp_o),
        .level_gain_apply_o(level_gain_apply_o));

    // 25 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic tick();
        @(posedge clk_i);
        #2;
    endtask : tick

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    // Value compare for register and output fields
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Duration compare, allowing a frame of phase plus synchroniser delay
    task automatic chk_dur(input int k, input int exp, input int got);
        num_checks++;
        if (got < exp - 12 || got > exp + 12) begin
            mismatches++;
            $display("BAD timer %0d expected %0d seen %0d", k, exp, got);
        end
    endtask : chk_dur

    function automatic logic busy(input int k);
        case (k)
            0: return line_switch_ramp_o;
            1: return phones_switch_ramp_o;
            2: return phones_power_ramp_o;
            3: return level_gain_ramp_o;
            default: return ~charge_pump_ready_o;
        endcase
    endfunction : busy

    function automatic logic [1:0] src(input logic en, input logic mix);
        return en ? (mix ? 2'h2 : 2'h1) : 2'h0;
    endfunction : src

    // One write pulse; the model keeps every write to a mapped register
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        k = (a == 8'h00) ? 0 : (a == 8'h08) ? 1 : (a == 8'h09) ? 2 : -1;
        if (k >= 0) mdl[k] = d;
        wr_addr_i = a;
        wr_data_i = d;
        wr_en_i = 1'b1;
        tick();
        wr_en_i = 1'b0;
        tick();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_addr_i = a;
        tick();
        tick();
        chk("readback", 16'(exp), 16'(rd_data_o));
    endtask : rd

    // Timer length in frames, converted to system clocks
    task automatic wait_ramp(input int k, input int frames);
        int n;
        n = 0;
        while (!busy(k) && n < 8) begin
            tick();
            n++;
        end
        n = 0;
        while (busy(k) && n < 60000) begin
            tick();
            n++;
        end
        if (n == 60000) begin
            mismatches++;
            test_done();
        end
        chk_dur(k, frames * 8, n);
    endtask : wait_ramp

    task automatic chk_out();
        logic [7:0] p, h, l;
        p = mdl[0];
        h = mdl[1];
        l = mdl[2];
        chk("power", 16'({p[7], p[3], p[2], p[1], p[0]}), 16'({phones_gain_high_o,
            charge_pump_on_o, phones_right_powered_o, phones_left_powered_o,
            line_stage_power_o}));
        chk("line", 16'({src(l[0], l[7]), src(l[3], l[7]), l[5], l[4], l[2], l[1]}),
            16'({line_left_dac_src_o, line_right_dac_src_o, line_input_paths_o}));
        chk("phones", 16'({src(h[0], phones_mono_mix_i), src(h[3], phones_mono_mix_i), h[5],
            h[4], h[2], h[1], ~h[6]}), 16'({phones_left_dac_src_o, phones_right_dac_src_o,
            phones_input_paths_o, phones_muted_o}));
    endtask : chk_out

    initial begin
        logic any;
        seed = 32'hFB4F69F1;
        {mismatches, num_checks} = '0;
        {resetn_i, wr_en_i, phones_mono_mix_i, level_gain_step_i} = '0;
        playback_level_control_enable_i = 1'b0;
        {wr_addr_i, wr_data_i, rd_addr_i} = '0;
        sample_rate_code_i = 4'hD;
        transition_time_sel_i = 2'h0;
        mdl = '{8'h00, 8'h00, 8'h00};
        repeat (16) tick();
        resetn_i = 1'b1;
        // Reset state, and an unmapped place that ignores writes
        tick();
        tick();
        chk("grounded", 16'h0001, 16'(phones_grounded_o));
        chk_out();
        wr(8'h05, 8'h5A);
        rd(8'h05, 8'h00);
        rd(8'h00, 8'h00);
        $display("test reset done");
        // Random paths with soft transition bypassed
        for (int i = 0; i < 24; i++) begin
            phones_mono_mix_i = 1'($random(seed));
            wr(8'h08, 8'($random(seed)) | 8'h80);
            wr(8'h09, 8'($random(seed)) | 8'h40);
            chk_out();
            rd(8'h08, mdl[1]);
            rd(8'h09, mdl[2]);
        end
        for (int i = 0; i < 12; i++) begin
            wr(8'h00, 8'($random(seed)) | 8'h10);
            chk_out();
            rd(8'h00, mdl[0]);
        end
        wr(8'h00, 8'h10);
        wr(8'h09, 8'h41);
        $display("test paths done");
        // Line transition and pump start-up at every rate code
        for (int j = 0; j < 9; j++) begin
            sample_rate_code_i = 4'(codes[j]);
            wr(8'h09, j[0] ? 8'h03 : 8'h01);
            wait_ramp(0, tr[j]);
            wr(8'h00, 8'h18);
            wait_ramp(4, cp[j]);
            wr(8'h00, 8'h10);
        end
        $display("test rates done");
        // Mute transition at each time setting, spaced past the transition
        sample_rate_code_i = 4'hD;
        wr(8'h08, 8'h80);
        for (int s = 0; s < 4; s++) begin
            transition_time_sel_i = 2'(s);
            wr(8'h08, s[0] ? 8'h00 : 8'h40);
            wait_ramp(1, 128 << s);
            chk_out();
        end
        $display("test mute done");
        // Power ramp up and down, pins grounded only when off and settled
        transition_time_sel_i = 2'h0;
        wr(8'h00, 8'h06);
        wait_ramp(2, 130);
        wr(8'h00, 8'h20);
        chk("grounded", 16'h0000, 16'(phones_grounded_o));
        wait_ramp(2, 258);
        tick();
        tick();
        chk("grounded", 16'h0001, 16'(phones_grounded_o));
        $display("test power done");
        // Repeat of the previous value starts nothing
        wr(8'h08, mdl[1]);
        any = 1'b0;
        repeat (4) begin
            any = any | phones_switch_ramp_o;
            tick();
        end
        chk("repeat", 16'h0000, 16'(any));
        $display("test repeat done");
        // Level-control gain step: ignored while disabled, then soft, then bypassed
        level_gain_step_i = 1'b1;
        tick();
        level_gain_step_i = 1'b0;
        chk("apply off", 16'h0000, 16'(level_gain_apply_o));
        tick();
        playback_level_control_enable_i = 1'b1;
        level_gain_step_i = 1'b1;
        tick();
        level_gain_step_i = 1'b0;
        chk("apply", 16'h0001, 16'(level_gain_apply_o));
        wait_ramp(3, 128);
        wr(8'h09, mdl[2] | 8'h40);
        level_gain_step_i = 1'b1;
        tick();
        level_gain_step_i = 1'b0;
        chk("apply", 16'h0001, 16'(level_gain_apply_o));
        tick();
        chk("gain ramp", 16'h0000, 16'(level_gain_ramp_o));
        $display("test gain done");
        test_done();
    end
endmodule : ops_output_path_bench
